// ==== src/i2c_seq_consts.vh ====
// Purpose: Shared constants of the two-wire start/transmit sequencer.
// Assumes: APB register byte addresses, 32-bit data.
// Notes:   Included by bare name.
`ifndef I2C_SEQ_CONSTS_VH
`define I2C_SEQ_CONSTS_VH

// Register byte offsets
`define OFS_CTRL2       8'h00
`define OFS_STATUS      8'h04
`define OFS_FLAGS       8'h08
`define OFS_HOLD_BUF    8'h0C
`define OFS_DIVIDER     8'h10

// control_reg_two fields
`define C2_START        0
`define C2_RESTART      1
`define C2_STOP         2
`define C2_ACK_RECEIVED_STATUS      6
`define C2_REQ_MASK     8'h1F

// status_reg fields
`define ST_BUF_FULL     0
`define ST_START_SEEN   3

// Flag register fields, write one to clear
`define FL_EVENT        0
`define FL_BUS_COLL     1
`define FL_WR_COLL      2

// Reset value and bits per byte
`define DIVIDER_RESET   8'h00
`define BITS_PER_BYTE   4'h8

`endif

// ==== src/bit_period_counter.v ====
// Purpose: Reloadable down-counter that times one bit period.
// Assumes: Load arms the counter; counting only while run is high.
// Notes:   Timeout is a one-cycle pulse; counter then stays suspended.
`timescale 1ns/1ps
`include "i2c_seq_consts.vh"

module bit_period_counter (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Control
    input  wire       load,
    input  wire       run,
    input  wire [7:0] reload,
    // Result
    output reg        timeout
);

reg [7:0] cnt_q;
reg       armed_q;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_q   <= 8'h00;
        armed_q <= 1'b0;
        timeout <= 1'b0;
    end else begin
        timeout <= 1'b0;
        if (load) begin
            cnt_q   <= reload;
            armed_q <= 1'b1;
        end else if (run && armed_q) begin
            if (cnt_q == 8'h00) begin
                timeout <= 1'b1;
                armed_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
end

endmodule

// ==== src/i2c_master_start_tx_sequencer.v ====
// Purpose: Controller-side Start, Repeated Start and byte transmit logic.
// Assumes: APB slave, one wait state per access; pins synchronous to pclk.
// Notes:   Lines are only pulled low or released, never driven high.
//
// Functional notes
// - Buffer write while busy sets write collision, buffer kept.
// - Request bit writes ignored while a Start is in progress.
// - Start request with both lines high reloads counter and counts.
// - First timeout with both lines high pulls SDA low, flags start.
// - Reload, next timeout clears start request, holds SDA low.
// - Lines low at begin, or SCL low early, is a bus collision.
// - Restart request only accepted while the sequencer is idle.
// - Restart pulls SCL low, then releases SDA for one bit period.
// - Restart releases SCL, both high, SDA low, SCL low, done.
// - Restart sets start seen as SDA is pulled low, event one timeout later.
// - Restart collision: SDA low at SCL rise, or SCL falls early.
// - Buffer write sets buffer full, starts counter and shifting.
// - Bits change after SCL falls; SCL low then high one period each.
// - SDA valid before SCL release and stable while SCL high.
// - After eighth clock fall, clear buffer full and release SDA.
// - Ninth bit sampled into ack status: zero ack, one no ack.
// - After ninth clock: event flag, counter stopped, SCL held low.
// - Address byte shifted most significant bit first, eight bits.
// - Start, address, data bytes, each completion raises the event.
// - Released SCL suspends counter until SCL sampled high, reload.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "i2c_seq_consts.vh"

module i2c_master_start_tx_sequencer (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Bus lines
    input  wire        scl_i,
    output reg         scl_o,
    output reg         scl_oe,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe
);

////////////////////////////////////////////////////////////////////////////
// States
localparam [10:0] S_IDLE = 11'h001;
localparam [10:0] S_STW  = 11'h002;
localparam [10:0] S_STH  = 11'h004;
localparam [10:0] S_RLO  = 11'h008;
localparam [10:0] S_RSH  = 11'h010;
localparam [10:0] S_RREL = 11'h020;
localparam [10:0] S_RBH  = 11'h040;
localparam [10:0] S_RSL  = 11'h080;
localparam [10:0] S_TLO  = 11'h100;
localparam [10:0] S_TREL = 11'h200;
localparam [10:0] S_THI  = 11'h400;

reg [10:0] state_q;
reg        start_q;
reg        restart_q;
reg        stop_q;
reg        ack_received_status_q;
reg        buf_full_q;
reg        start_seen_q;
reg        event_q;
reg        bus_coll_q;
reg        wr_coll_q;
reg [7:0]  hold_buf_q;
reg [7:0]  divider_q;
reg [7:0]  shift_q;
reg [3:0]  bitcnt_q;
reg        pend_q;
reg        load_q;

wire       tmo;
wire       acc     = psel && penable && pready;
wire       wr      = acc && pwrite;
wire       wr_c2   = wr && (paddr == `OFS_CTRL2);
wire       wr_fl   = wr && (paddr == `OFS_FLAGS);
wire       wr_buf  = wr && (paddr == `OFS_HOLD_BUF);
wire       wr_div  = wr && (paddr == `OFS_DIVIDER);
wire       idle    = (state_q == S_IDLE) && !start_q && !restart_q;
wire       run     = (state_q == S_STW) || (state_q == S_STH) ||
                     (state_q == S_RSH) || (state_q == S_RBH) ||
                     (state_q == S_RSL) || (state_q == S_TLO) ||
                     (state_q == S_THI);

function is_mapped;
    input [7:0] a;
    begin
        is_mapped = (a == `OFS_CTRL2) || (a == `OFS_STATUS) ||
                    (a == `OFS_FLAGS) || (a == `OFS_HOLD_BUF) ||
                    (a == `OFS_DIVIDER);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Bit period timing
bit_period_counter u_bpc (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (load_q),
    .run     (run),
    .reload  (divider_q),
    .timeout (tmo)
);

////////////////////////////////////////////////////////////////////////////
// APB answer: one wait state, registered read data
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= !is_mapped(paddr);
            prdata  <= 32'h0000_0000;
            case (paddr)
            `OFS_CTRL2: begin
                prdata[`C2_START]   <= start_q;
                prdata[`C2_RESTART] <= restart_q;
                prdata[`C2_STOP]    <= stop_q;
                prdata[`C2_ACK_RECEIVED_STATUS] <= ack_received_status_q;
            end
            `OFS_STATUS: begin
                prdata[`ST_BUF_FULL]   <= buf_full_q;
                prdata[`ST_START_SEEN] <= start_seen_q;
            end
            `OFS_FLAGS: begin
                prdata[`FL_EVENT]    <= event_q;
                prdata[`FL_BUS_COLL] <= bus_coll_q;
                prdata[`FL_WR_COLL]  <= wr_coll_q;
            end
            `OFS_HOLD_BUF: prdata[7:0] <= hold_buf_q;
            `OFS_DIVIDER:  prdata[7:0] <= divider_q;
            default:       prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Sequencer
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_q      <= S_IDLE;
        start_q      <= 1'b0;
        restart_q    <= 1'b0;
        stop_q       <= 1'b0;
        ack_received_status_q    <= 1'b0;
        buf_full_q   <= 1'b0;
        start_seen_q <= 1'b0;
        event_q      <= 1'b0;
        bus_coll_q   <= 1'b0;
        wr_coll_q    <= 1'b0;
        hold_buf_q   <= 8'h00;
        divider_q    <= `DIVIDER_RESET;
        shift_q      <= 8'h00;
        bitcnt_q     <= 4'h0;
        pend_q       <= 1'b0;
        load_q       <= 1'b0;
        scl_o        <= 1'b0;
        sda_o        <= 1'b0;
        scl_oe       <= 1'b0;
        sda_oe       <= 1'b0;
    end else begin
        load_q <= 1'b0;
        scl_o  <= 1'b0;
        sda_o  <= 1'b0;
        if (wr_div)
            divider_q <= pwdata[7:0];
        // Flags: software clear first, hardware set below wins
        if (wr_fl) begin
            if (pwdata[`FL_EVENT])    event_q    <= 1'b0;
            if (pwdata[`FL_BUS_COLL]) bus_coll_q <= 1'b0;
            if (pwdata[`FL_WR_COLL])  wr_coll_q  <= 1'b0;
        end
        if (wr_c2 && !start_q) begin
            stop_q <= pwdata[`C2_STOP];
            if (pwdata[`C2_START] && idle)
                start_q <= 1'b1;
            if (pwdata[`C2_RESTART] && idle)
                restart_q <= 1'b1;
        end
        if (wr_buf) begin
            if (!idle || stop_q) begin
                wr_coll_q <= 1'b1;
            end else begin
                hold_buf_q <= pwdata[7:0];
                shift_q    <= pwdata[7:0];
                buf_full_q <= 1'b1;
                bitcnt_q   <= 4'h0;
                pend_q     <= 1'b1;
                scl_oe     <= 1'b1;
                load_q     <= 1'b1;
                state_q    <= S_TLO;
            end
        end
        case (state_q)
        S_IDLE: begin
            if (start_q) begin
                if (!scl_i && !sda_i) begin
                    bus_coll_q <= 1'b1;
                    start_q    <= 1'b0;
                end else if (scl_i && sda_i) begin
                    load_q  <= 1'b1;
                    state_q <= S_STW;
                end
            end else if (restart_q) begin
                scl_oe  <= 1'b1;
                state_q <= S_RLO;
            end
        end
        S_STW: begin
            if (!scl_i) begin
                bus_coll_q <= 1'b1;
                start_q    <= 1'b0;
                scl_oe     <= 1'b0;
                sda_oe     <= 1'b0;
                state_q    <= S_IDLE;
            end else if (tmo) begin
                if (sda_i) begin
                    sda_oe       <= 1'b1;
                    start_seen_q <= 1'b1;
                    load_q       <= 1'b1;
                    state_q      <= S_STH;
                end else begin
                    bus_coll_q <= 1'b1;
                    start_q    <= 1'b0;
                    state_q    <= S_IDLE;
                end
            end
        end
        S_STH: begin
            if (tmo) begin
                start_q <= 1'b0;
                event_q <= 1'b1;
                state_q <= S_IDLE;
            end
        end
        S_RLO: begin
            if (!scl_i) begin
                sda_oe  <= 1'b0;
                load_q  <= 1'b1;
                state_q <= S_RSH;
            end
        end
        S_RSH: begin
            if (tmo) begin
                if (sda_i) begin
                    scl_oe  <= 1'b0;
                    state_q <= S_RREL;
                end else begin
                    bus_coll_q <= 1'b1;
                    restart_q  <= 1'b0;
                    scl_oe     <= 1'b0;
                    state_q    <= S_IDLE;
                end
            end
        end
        S_RREL: begin
            if (scl_i) begin
                if (!sda_i) begin
                    bus_coll_q <= 1'b1;
                    restart_q  <= 1'b0;
                    state_q    <= S_IDLE;
                end else begin
                    load_q  <= 1'b1;
                    state_q <= S_RBH;
                end
            end
        end
        S_RBH: begin
            if (!scl_i) begin
                bus_coll_q <= 1'b1;
                restart_q  <= 1'b0;
                state_q    <= S_IDLE;
            end else if (tmo) begin
                sda_oe       <= 1'b1;
                start_seen_q <= 1'b1;
                load_q       <= 1'b1;
                state_q      <= S_RSL;
            end
        end
        S_RSL: begin
            if (tmo) begin
                scl_oe    <= 1'b1;
                restart_q <= 1'b0;
                event_q   <= 1'b1;
                state_q   <= S_IDLE;
            end
        end
        S_TLO: begin
            // Data changes only once SCL is seen low
            if (pend_q && !scl_i) begin
                pend_q <= 1'b0;
                if (bitcnt_q == `BITS_PER_BYTE) begin
                    sda_oe     <= 1'b0;
                    buf_full_q <= 1'b0;
                end else begin
                    sda_oe  <= !shift_q[7];
                    shift_q <= {shift_q[6:0], 1'b0};
                end
            end
            if (tmo) begin
                scl_oe  <= 1'b0;
                state_q <= S_TREL;
            end
        end
        S_TREL: begin
            if (scl_i) begin
                load_q  <= 1'b1;
                state_q <= S_THI;
            end
        end
        S_THI: begin
            if (tmo) begin
                scl_oe <= 1'b1;
                if (bitcnt_q == `BITS_PER_BYTE) begin
                    ack_received_status_q <= sda_i;
                    event_q   <= 1'b1;
                    state_q   <= S_IDLE;
                end else begin
                    bitcnt_q <= bitcnt_q + 4'h1;
                    pend_q   <= 1'b1;
                    load_q   <= 1'b1;
                    state_q  <= S_TLO;
                end
            end
        end
        default: state_q <= S_IDLE;
        endcase
    end
end

endmodule

// ==== verif/i2c_seq_asserts.sv ====
// Purpose: Port-level checks of the start/transmit sequencer.
// Assumes: Line inputs are the resolved wire levels.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
module i2c_seq_asserts (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Lines
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////
    sequence apb_wait;
        psel && penable && !pready;
    endsequence
    sequence scl_rise;
        $rose(scl_i);
    endsequence
    lines_low_a: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    sda_release_a: assert property ($fell(sda_oe) |-> scl_oe && $past(scl_oe))
        else $error("sda released while scl not held low");
    start_cond_a: assert property ($rose(sda_oe) && !scl_oe |->
        $past(scl_i) && $past(sda_i))
        else $error("sda pulled with scl high but lines not idle");
    scl_high_min_a: assert property (scl_rise |-> !scl_oe [*4])
        else $error("scl high phase too short");
    scl_low_min_a: assert property ($rose(scl_oe) |-> scl_oe [*2])
        else $error("scl low phase too short");
    apb_answer_a: assert property (apb_wait |=> pready)
        else $error("apb answer late");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_qual_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside access");
endmodule

// ==== verif/i2c_target_model.sv ====
// Purpose: Behavioural target on the two-wire bus.
// Assumes: Lines have pull-ups; sda_pull high pulls SDA low.
// Notes:   Acknowledges each byte when ack_en is high.
`timescale 1ns/1ps
module i2c_target_model (
    // Lines
    input  wire       scl,
    input  wire       sda,
    // Control and capture
    input  wire       ack_en,
    output reg        sda_pull,
    output reg  [7:0] rx_byte
);
    reg [3:0] cnt;
    reg       scl_was;
    initial begin
        sda_pull = 1'b0;
        rx_byte  = 8'h00;
        cnt      = 4'h0;
        scl_was  = 1'b1;
    end
    // One process follows both lines so each variable has one driver
    always @(scl or sda) begin
        if (scl && scl_was) begin
            // SDA falling while SCL stays high is a Start
            if (!sda)
                cnt <= 4'h0;
        end else if (scl && !scl_was) begin
            if (cnt < 4'h8) begin
                rx_byte <= {rx_byte[6:0], sda};
                cnt     <= cnt + 4'h1;
            end
        end else if (!scl && scl_was) begin
            // Ninth bit: pull low to accept, release afterwards
            if (cnt == 4'h8) begin
                sda_pull <= ack_en;
                cnt      <= 4'h9;
            end else if (cnt == 4'h9) begin
                sda_pull <= 1'b0;
                cnt      <= 4'h0;
            end
        end
        scl_was = scl;
    end
endmodule

// ==== verif/i2c_master_start_tx_sequencer_test.sv ====
// Purpose: Register-driven test of start, restart and transmit.
// Assumes: APB master timing, one clock, 8 ns period.
// Notes:   Lines resolved from all pull-down enables.
`timescale 1ns/1ps
`include "i2c_seq_consts.vh"
module i2c_master_start_tx_sequencer_test;
    reg         pclk, presetn, psel, penable, pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, r;
    wire [31:0] prdata;
    wire        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
    wire        scl_i, sda_i, tgt_pull;
    wire [7:0]  tgt_byte;
    reg         scl_hold, sda_hold, ack_en, last_err;
    integer     error_cnt, n_checks;
    assign scl_i = !(scl_oe | scl_hold);
    assign sda_i = !(sda_oe | tgt_pull | sda_hold);
    i2c_master_start_tx_sequencer i2c_master_start_tx_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
    i2c_target_model i2c_target_model_inst (.scl(scl_i), .sda(sda_i),
        .ack_en(ack_en), .sda_pull(tgt_pull), .rx_byte(tgt_byte));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: saw %h expected %h",
                         $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w;
            paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            // Sample pready at each rising edge; the watchdog ends a hang
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            r = prdata;
            last_err = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask
    task wait_flag(input [31:0] mask);
        begin
            r = 32'h0;
            while ((r & mask) == 0)
                apb(1'b0, `OFS_FLAGS, 32'h0);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        presetn = 0; scl_hold = 0; sda_hold = 0; ack_en = 1;
        error_cnt = 0; n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFS_DIVIDER, 0); check(r, {24'h0, `DIVIDER_RESET});
        apb(0, `OFS_CTRL2, 0); check(r, 32'h0);
        apb(0, 8'h20, 0); check({31'h0, last_err}, 32'h1);
        apb(1, `OFS_DIVIDER, 32'h3);
        apb(0, `OFS_DIVIDER, 0); check(r, 32'h3);
        // Start with a buffer write and a restart request thrown at it, both refused
        apb(1, `OFS_CTRL2, 32'h1);
        apb(1, `OFS_HOLD_BUF, 32'hFF);
        apb(1, `OFS_CTRL2, 32'h6);
        wait_flag(32'h1); check(r & 32'h5, 32'h5);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h1F, 32'h0);
        apb(0, `OFS_STATUS, 0); check(r & 32'h9, 32'h8);
        check({30'h0, scl_i, sda_i}, 32'h2);
        apb(1, `OFS_FLAGS, 32'h7);
        apb(0, `OFS_FLAGS, 0); check(r & 32'h7, 32'h0);
        // Address byte, accepted
        apb(1, `OFS_HOLD_BUF, 32'hA4);
        apb(0, `OFS_STATUS, 0); check(r & 32'h1, 32'h1);
        // Stretch a low phase from outside; the high phase must wait
        wait (scl_oe === 1'b1);
        @(posedge pclk);
        scl_hold <= 1'b1;
        repeat (30) @(posedge pclk);
        check({31'h0, scl_oe}, 32'h0);
        scl_hold <= 1'b0;
        wait_flag(32'h1); check(r & 32'h7, 32'h1);
        check({24'h0, tgt_byte}, 32'hA4);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h47, 32'h0);
        apb(0, `OFS_STATUS, 0); check(r & 32'h1, 32'h0);
        check({30'h0, scl_i, sda_i}, 32'h1);
        // Data byte, refused, with writes thrown at it in flight
        ack_en <= 1'b0;
        apb(1, `OFS_FLAGS, 32'h1);
        apb(1, `OFS_HOLD_BUF, 32'h5B);
        apb(1, `OFS_HOLD_BUF, 32'h00);
        apb(1, `OFS_CTRL2, 32'h2);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h2, 32'h0);
        wait_flag(32'h1); check(r & 32'h5, 32'h5);
        check({24'h0, tgt_byte}, 32'h5B);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h40, 32'h40);
        // Repeated start
        apb(1, `OFS_FLAGS, 32'h7);
        apb(1, `OFS_CTRL2, 32'h2);
        apb(0, `OFS_FLAGS, 0); check(r & 32'h1, 32'h0);
        wait_flag(32'h1);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h3, 32'h0);
        check({30'h0, scl_i, sda_i}, 32'h0);
        // Second restart, SCL pulled low by another party while high
        apb(1, `OFS_FLAGS, 32'h7);
        apb(1, `OFS_CTRL2, 32'h2);
        wait (scl_oe === 1'b0);
        repeat (2) @(posedge pclk);
        scl_hold <= 1'b1;
        apb(0, `OFS_FLAGS, 0); check(r & 32'h3, 32'h2);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h2, 32'h0);
        scl_hold <= 1'b0;
        // Mid-run reset, then a start on a bus held low
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1; scl_hold <= 1'b1; sda_hold <= 1'b1;
        apb(0, `OFS_STATUS, 0); check(r, 32'h0);
        apb(1, `OFS_CTRL2, 32'h1);
        wait_flag(32'h2); check(r & 32'h3, 32'h2);
        apb(0, `OFS_CTRL2, 0); check(r & 32'h1, 32'h0);
        check({30'h0, scl_oe, sda_oe}, 32'h0);
        // Start that loses SCL before SDA is pulled
        apb(1, `OFS_FLAGS, 32'h7);
        scl_hold <= 1'b0; sda_hold <= 1'b0;
        apb(1, `OFS_CTRL2, 32'h1);
        @(posedge pclk);
        scl_hold <= 1'b1;
        apb(0, `OFS_FLAGS, 0); check(r & 32'h3, 32'h2);
        apb(0, `OFS_STATUS, 0); check(r & 32'h8, 32'h0);
        scl_hold <= 1'b0;
        // Stored stop request refuses a buffer write
        apb(1, `OFS_FLAGS, 32'h7);
        apb(1, `OFS_CTRL2, 32'h4);
        apb(1, `OFS_HOLD_BUF, 32'h12);
        apb(0, `OFS_FLAGS, 0); check(r & 32'h4, 32'h4);
        apb(0, `OFS_STATUS, 0); check(r & 32'h1, 32'h0);
        report_and_stop;
    end
endmodule
bind i2c_master_start_tx_sequencer i2c_seq_asserts i2c_seq_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
